/* File: include/latency_stopwatch_pkg.sv */
/*
  Package for the latency stopwatch: register offsets, field positions,
  reset values and the stopwatch state encoding.
  Assumes a 16-bit management register space addressed by word offset.
  // Operation
  // - Bits 7:6 pick stop point
  // - Bits 5:4 divide VCO clock 1/2/4/8
  // - Bits 3:2 pick start point
  // - Measure only while bit 1 set
  // - Bit 0 picks VCO or byte clock
  // - Start marker flags latch in 15:12
  // - Stop marker flags latch in 11:8
  // - Ready flag bit 4 after measurement
  // - Twenty-bit count split across two registers
  // - Count advances each measurement half period
  // - Count reads zero before stop marker
  // - Count saturates at all ones
  // - Lower read clears count and flags
  // - Upper read clears stopwatch status
*/
package latency_stopwatch_pkg;

  // Register offsets
  localparam logic [15:0] OFFSET_CONTROL     = 16'h8040;
  localparam logic [15:0] OFFSET_RESULT_UP   = 16'h8041;
  localparam logic [15:0] OFFSET_RESULT_LOW  = 16'h8042;

  // Reset values
  localparam logic [15:0] RESET_CONTROL      = 16'h0000;
  localparam logic [19:0] RESET_COUNT        = 20'h00000;

  // Control field positions
  localparam int STOP_SEL_HI   = 7;
  localparam int STOP_SEL_LO   = 6;
  localparam int DIV_HI        = 5;
  localparam int DIV_LO        = 4;
  localparam int START_SEL_HI  = 3;
  localparam int START_SEL_LO  = 2;
  localparam int ENABLE_BIT    = 1;
  localparam int CLK_SRC_BIT   = 0;
  localparam int CONTROL_BITS  = 8;

  // Point select codes; upper bit set means external pin
  localparam logic [1:0] SEL_LOW_SPEED  = 2'h0;
  localparam logic [1:0] SEL_HIGH_SPEED = 2'h1;

  // Count geometry
  localparam int COUNT_WIDTH   = 20;
  localparam int COUNT_LOW_W   = 16;
  localparam logic [19:0] COUNT_MAX = 20'hfffff;

  // Upper result register field positions
  localparam int START_FLAG_LO = 12;
  localparam int STOP_FLAG_LO  = 8;
  localparam int READY_BIT     = 4;

  // Stopwatch states
  typedef enum logic [1:0] {
    SW_IDLE    = 2'b00,
    SW_RUNNING = 2'b01,
    SW_DONE    = 2'b10
  } sw_state_type;

endpackage : latency_stopwatch_pkg

/* File: src/latency_stopwatch.sv */
/*
  Latency stopwatch: counts from a marker at a selectable start point to a
  marker at a selectable stop point, in half periods of a measurement clock.
  Assumes marker strobes and half-period ticks come from logic on clk, one
  cycle each; the external trigger pin is asynchronous and is synchronised.
  Register access is a simple word port: read data returns one cycle later.
*/
`timescale 1ns/1ps
module latency_stopwatch
  import latency_stopwatch_pkg::*;
(
  input  wire logic        clk,                  // System clock, 250 MHz
  input  wire logic        rst,                  // Synchronous reset, active high
  input  wire logic [15:0] reg_addr,             // Register word offset
  input  wire logic        reg_write,            // Write strobe
  input  wire logic [15:0] reg_wdata,            // Write data
  input  wire logic        reg_read,             // Read strobe
  output logic      [15:0] reg_rdata,            // Read data, registered
  output logic             reg_rvalid,           // Read data valid pulse
  input  wire logic [3:0]  ls_tx_marker,         // Low-speed transmit lane markers
  input  wire logic [1:0]  hs_rx_marker,         // High-speed receive halves
  input  wire logic [3:0]  ls_rx_marker,         // Low-speed receive lane markers
  input  wire logic [1:0]  hs_tx_marker,         // High-speed transmit halves
  input  wire logic        external_trigger_pin, // Asynchronous trigger pin
  input  wire logic        vco_half_tick,        // VCO clock half-period pulse
  input  wire logic        byte_half_tick,       // Recovered byte clock half-period pulse
  output logic             measuring             // High while the count runs
);

  logic [CONTROL_BITS-1:0] control;         // Stored control bits
  logic [1:0]              pin_sync;        // Two-stage pin synchroniser
  logic                    pin_last;        // Previous synchronised pin level
  logic                    pin_event;       // Rising edge of the pin
  logic [2:0]              div_count;       // VCO tick divider
  logic [2:0]              div_max;         // Divider terminal count
  logic                    tick;            // Counting tick
  logic [3:0]              start_hit;       // Start markers at chosen point
  logic [3:0]              stop_hit;        // Stop markers at chosen point
  logic [3:0]              start_marker_found; // Latched start flags
  logic [3:0]              stop_marker_found;  // Latched stop flags
  logic                    result_valid;    // Latched ready flag
  logic [COUNT_WIDTH-1:0]  elapsed_count;   // Saturating count
  logic [15:0]             low_hold;        // Low count captured at upper read
  logic [COUNT_WIDTH-1:0]  shown_count;     // Count as software sees it
  logic                    read_upper;      // Upper register read this cycle
  logic                    read_lower;      // Lower register read this cycle
  logic                    clear_all;       // Any clearing read
  sw_state_type            state;           // Stopwatch state
  sw_state_type            next_state;      // Next stopwatch state

  assign read_upper = reg_read && (reg_addr == OFFSET_RESULT_UP);
  assign read_lower = reg_read && (reg_addr == OFFSET_RESULT_LOW);
  assign clear_all  = read_upper || read_lower;

  // Control register; only the low byte is stored, the rest reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      control <= RESET_CONTROL[CONTROL_BITS-1:0];
    end else if (reg_write && reg_addr == OFFSET_CONTROL) begin
      control <= reg_wdata[CONTROL_BITS-1:0];
    end
  end

  // Pin passes two flops before the edge detector looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync <= 2'h0;
      pin_last <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], external_trigger_pin};
      pin_last <= pin_sync[1];
    end
  end
  assign pin_event = pin_sync[1] && !pin_last;

  // Marker routing by point select
  always_comb begin
    unique case (control[START_SEL_HI:START_SEL_LO])
      SEL_LOW_SPEED:  start_hit = ls_tx_marker;
      SEL_HIGH_SPEED: start_hit = {2'h0, hs_rx_marker};
      default:        start_hit = {3'h0, pin_event};
    endcase
    unique case (control[STOP_SEL_HI:STOP_SEL_LO])
      SEL_LOW_SPEED:  stop_hit = ls_rx_marker;
      SEL_HIGH_SPEED: stop_hit = {2'h0, hs_tx_marker};
      default:        stop_hit = {3'h0, pin_event};
    endcase
  end

  // Divider: terminal count 0, 1, 3 or 7 for divide by 1, 2, 4, 8
  always_comb begin
    unique case (control[DIV_HI:DIV_LO])
      2'h0:    div_max = 3'h0;
      2'h1:    div_max = 3'h1;
      2'h2:    div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end

  // VCO tick prescaler; restarts with each measurement for a clean phase
  always_ff @(posedge clk) begin
    if (rst || state != SW_RUNNING) begin
      div_count <= 3'h0;
    end else if (vco_half_tick) begin
      div_count <= (div_count >= div_max) ? 3'h0 : div_count + 3'h1;
    end
  end

  // Counting tick: byte clock bypasses the divider
  assign tick = control[CLK_SRC_BIT] ? byte_half_tick
              : (vco_half_tick && div_count >= div_max);

  // Stopwatch sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      SW_IDLE:    if (control[ENABLE_BIT] && |start_hit) begin
                    next_state = SW_RUNNING;
                  end
      SW_RUNNING: if (!control[ENABLE_BIT]) begin
                    next_state = SW_IDLE;
                  end else if (|stop_hit) begin
                    next_state = SW_DONE;
                  end
      SW_DONE:    if (clear_all) begin
                    next_state = SW_IDLE;
                  end
      default:    next_state = SW_IDLE;                            // Illegal code
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Elapsed count: saturates, cleared by a lower read or a fresh start
  always_ff @(posedge clk) begin
    if (rst) begin
      elapsed_count <= RESET_COUNT;
    end else if (state == SW_IDLE && next_state == SW_RUNNING) begin
      elapsed_count <= RESET_COUNT;
    end else if (read_lower) begin
      elapsed_count <= RESET_COUNT;
    end else if (state == SW_RUNNING && tick && elapsed_count != COUNT_MAX) begin
      elapsed_count <= elapsed_count + 20'h00001;
    end
  end

  // Status flags: a marker in the clearing cycle still sets its flag
  always_ff @(posedge clk) begin
    if (rst) begin
      start_marker_found <= 4'h0;
      stop_marker_found  <= 4'h0;
      result_valid       <= 1'b0;
    end else begin
      start_marker_found <= (clear_all ? 4'h0 : start_marker_found)
                          | ((state == SW_IDLE && control[ENABLE_BIT])
                             ? start_hit : 4'h0);
      stop_marker_found  <= (clear_all ? 4'h0 : stop_marker_found)
                          | ((state == SW_RUNNING && control[ENABLE_BIT])
                             ? stop_hit : 4'h0);
      result_valid       <= (clear_all ? 1'b0 : result_valid)
                          | (state == SW_RUNNING && next_state == SW_DONE);
    end
  end

  // Count is hidden until the stop marker has arrived
  assign shown_count = result_valid ? elapsed_count : RESET_COUNT;

  // Upper read captures the low half so the pair stays coherent
  always_ff @(posedge clk) begin
    if (rst) begin
      low_hold <= 16'h0000;
    end else if (read_upper) begin
      low_hold <= shown_count[COUNT_LOW_W-1:0];
    end
  end

  // Read mux, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (!reg_read) begin
        reg_rdata <= reg_rdata;
      end else if (reg_addr == OFFSET_CONTROL) begin
        reg_rdata <= {8'h00, control};
      end else if (reg_addr == OFFSET_RESULT_UP) begin
        reg_rdata <= {start_marker_found, stop_marker_found, 3'h0, result_valid,
                      shown_count[COUNT_WIDTH-1:COUNT_LOW_W]};
      end else if (reg_addr == OFFSET_RESULT_LOW) begin
        reg_rdata <= low_hold;
      end else begin
        reg_rdata <= 16'h0000;                                  // Unmapped
      end
    end
  end

  // Busy indication for the datapath
  always_ff @(posedge clk) begin
    if (rst) begin
      measuring <= 1'b0;
    end else begin
      measuring <= (next_state == SW_RUNNING);
    end
  end

  // Checks
  a_disabled_no_start: assert property (@(posedge clk) disable iff (rst)
    (state == SW_IDLE && !control[ENABLE_BIT]) |=> state == SW_IDLE)
    else $error("Stopwatch started while disabled");

  a_start_runs: assert property (@(posedge clk) disable iff (rst)
    (state == SW_IDLE && control[ENABLE_BIT] && |start_hit) |=> state == SW_RUNNING)
    else $error("Start marker did not start the stopwatch");

  a_stop_ready: assert property (@(posedge clk) disable iff (rst)
    (state == SW_RUNNING && control[ENABLE_BIT] && |stop_hit) |=> result_valid)
    else $error("Ready flag not set after stop marker");

  a_count_saturates: assert property (@(posedge clk) disable iff (rst)
    (elapsed_count == COUNT_MAX && !read_lower && state != SW_IDLE) |=>
    elapsed_count == COUNT_MAX)
    else $error("Count wrapped past maximum");

  a_count_advances: assert property (@(posedge clk) disable iff (rst)
    (state == SW_RUNNING && next_state == SW_RUNNING && tick && !read_lower
     && elapsed_count != COUNT_MAX) |=> elapsed_count == $past(elapsed_count) + 20'h00001)
    else $error("Count did not advance on tick");

  a_lower_clears: assert property (@(posedge clk) disable iff (rst)
    (read_lower && !(state == SW_RUNNING && |stop_hit)) |=>
    elapsed_count == RESET_COUNT && !result_valid)
    else $error("Lower read did not clear the result");

  a_hidden_count: assert property (@(posedge clk) disable iff (rst)
    (read_upper && !result_valid) |=> reg_rvalid && reg_rdata[3:0] == 4'h0 ##0
    low_hold == 16'h0000)
    else $error("Count visible before stop marker");

  a_upper_clears: assert property (@(posedge clk) disable iff (rst)
    (read_upper && state == SW_DONE) |=> !result_valid && state == SW_IDLE)
    else $error("Upper read did not clear status");

  a_byte_source: assert property (@(posedge clk) disable iff (rst)
    (control[CLK_SRC_BIT] && !byte_half_tick) |-> !tick)
    else $error("Tick without byte clock in byte mode");

  a_start_flag: assert property (@(posedge clk) disable iff (rst)
    (state == SW_IDLE && control[ENABLE_BIT] && start_hit[0]) |=> start_marker_found[0])
    else $error("Start flag not latched");

endmodule : latency_stopwatch

/* File: bench/tb_latency_stopwatch.sv */
/*
  Self-checking bench for the latency stopwatch: control read-back, start and
  stop point selection, clock source and divider, read-to-clear results.
  Assumes the package is compiled first and the plain word register port.
*/
`timescale 1ns/1ps
module tb_latency_stopwatch
  import latency_stopwatch_pkg::*;
  ;
  logic        clk;                  // Bench clock
  logic        rst;                  // Synchronous reset
  logic [15:0] reg_addr;             // Register offset
  logic        reg_write;            // Write strobe
  logic [15:0] reg_wdata;            // Write data
  logic        reg_read;             // Read strobe
  logic [15:0] reg_rdata;            // Read data
  logic        reg_rvalid;           // Read data valid
  logic [3:0]  ls_tx_marker;         // Low-speed start markers
  logic [1:0]  hs_rx_marker;         // High-speed start markers
  logic [3:0]  ls_rx_marker;         // Low-speed stop markers
  logic [1:0]  hs_tx_marker;         // High-speed stop markers
  logic        external_trigger_pin; // Shared pin trigger
  logic        vco_half_tick;        // VCO half-period pulse
  logic        byte_half_tick;       // Byte clock half-period pulse
  logic        measuring;            // Run indicator
  int          fail_count;           // Mismatches seen
  int          n_compared;           // Comparisons made
  int          cycles;               // Watchdog count
  logic [31:0] lfsr = 32'hc0c8;      // Random state, fixed seed
  logic [15:0] d, c, m;              // Read data, control word, flag mask
  logic [31:0] r;                    // Random draw
  logic [1:0]  ss, ps, dv;           // Start, stop, divider codes
  logic        src;                  // Clock source
  logic [3:0]  ls, lp;               // Start and stop lane patterns
  logic [19:0] cnt;                  // Expected count
  int          nv, nb;               // Tick counts per source

  latency_stopwatch latency_stopwatch_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ls_tx_marker(ls_tx_marker),
    .hs_rx_marker(hs_rx_marker), .ls_rx_marker(ls_rx_marker),
    .hs_tx_marker(hs_tx_marker), .external_trigger_pin(external_trigger_pin),
    .vco_half_tick(vco_half_tick), .byte_half_tick(byte_half_tick),
    .measuring(measuring));

  // 250 MHz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Watchdog; the full run needs well under a tenth of this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Fibonacci shift register, taps 32/22/2/1
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Byte ticks are never divided; VCO ticks are, and VCO tick counts are multiples of 8
  function automatic logic [19:0] exp_count(input logic s, input logic [1:0] v,
                                            input int a, input int b);
    return 20'(s ? b : a >> v);
  endfunction : exp_count

  // High-speed points only report the two data halves
  function automatic logic [15:0] exp_upper(input logic [1:0] a, input logic [3:0] la,
      input logic [1:0] b, input logic [3:0] lb, input logic [19:0] n);
    logic [3:0] sf;
    logic [3:0] pf;
    sf = a[1] ? 4'h1 : a[0] ? {2'b00, la[1:0]} : la;
    pf = b[1] ? 4'h1 : b[0] ? {2'b00, lb[1:0]} : lb;
    return {sf, pf, 3'b000, 1'b1, n[19:16]};
  endfunction : exp_upper

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Answer lands exactly one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    v = reg_rdata;
  endtask : rd

  // One marker; pin held long enough to pass its synchroniser, then low again
  task automatic mark(input logic stop, input logic [1:0] sel, input logic [3:0] ln);
    @(posedge clk);
    if (sel[1]) external_trigger_pin <= 1'b1;
    else if (stop && sel[0]) hs_tx_marker <= ln[1:0];
    else if (stop) ls_rx_marker <= ln;
    else if (sel[0]) hs_rx_marker <= ln[1:0];
    else ls_tx_marker <= ln;
    @(posedge clk);
    {ls_tx_marker, ls_rx_marker, hs_rx_marker, hs_tx_marker} <= 12'h000;
    repeat (5) @(posedge clk);
    external_trigger_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : mark

  // Ticks on alternate cycles so every pulse is distinct
  task automatic ticks(input int a, input int b);
    for (int i = 0; i < 2 * (a > b ? a : b); i++) begin
      @(posedge clk);
      vco_half_tick  <= !i[0] && (i / 2 < a);
      byte_half_tick <= !i[0] && (i / 2 < b);
    end
    @(posedge clk);
    {vco_half_tick, byte_half_tick} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask : ticks

  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {ls_tx_marker, hs_rx_marker, ls_rx_marker, hs_tx_marker} = '0;
    {external_trigger_pin, vco_half_tick, byte_half_tick} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(OFFSET_CONTROL, d); chk(d, RESET_CONTROL);
    rd(OFFSET_RESULT_UP, d); chk(d, 16'h0000);
    rd(OFFSET_RESULT_LOW, d); chk(d, 16'h0000);
    rd(16'h8043, d); chk(d, 16'h0000);
    // Every start and stop pairing, random divider, source and lanes
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      ss = 2'(k); ps = 2'(k >> 2); dv = r[5:4]; src = r[0];
      ls = r[11:8] | 4'h1; lp = r[15:12] | 4'h1;
      nv = 8 * (1 + int'(r[18:16])); nb = 1 + int'(r[23:19]);
      c = {8'h00, ps, dv, ss, 1'b1, src};
      wr(OFFSET_CONTROL, {r[31:24], c[7:0]});
      rd(OFFSET_CONTROL, d); chk(d, c);
      // Decoy at the unselected start point must not start the run
      mark(1'b0, ss == 2'd1 ? 2'd0 : 2'd1, ls);
      ticks(8, 8);
      mark(1'b0, ss, ls); chk({15'h0000, measuring}, 16'h0001);
      mark(1'b1, ps == 2'd1 ? 2'd0 : 2'd1, lp);
      ticks(nv, nb);
      mark(1'b1, ps, lp); chk({15'h0000, measuring}, 16'h0000);
      // A new start while done is ignored
      mark(1'b0, ss, ls);
      ticks(8, 8);
      cnt = exp_count(src, dv, nv, nb);
      m = 16'hffff;
      rd(OFFSET_RESULT_UP, d); chk(d & m, exp_upper(ss, ls, ps, lp, cnt) & m);
      rd(OFFSET_RESULT_LOW, d); chk(d, cnt[15:0]);
      rd(OFFSET_RESULT_UP, d); chk(d, 16'h0000);
    end
    // Disabled: markers and ticks leave nothing behind
    wr(OFFSET_CONTROL, 16'h0000);
    mark(1'b0, 2'd0, 4'hf); ticks(8, 8); mark(1'b1, 2'd0, 4'hf);
    rd(OFFSET_RESULT_UP, d); chk(d, 16'h0000);
    // Reading before the stop marker gives a zero count
    wr(OFFSET_CONTROL, 16'h0002);
    mark(1'b0, 2'd0, 4'h3); ticks(16, 0);
    rd(OFFSET_RESULT_UP, d); chk(d & 16'h001f, 16'h0000);
    rd(OFFSET_RESULT_LOW, d); chk(d, 16'h0000);
    // Dropping enable mid-run abandons it; a fresh run counts from zero
    wr(OFFSET_CONTROL, 16'h0000);
    wr(OFFSET_CONTROL, 16'h0002);
    mark(1'b0, 2'd0, 4'h3); ticks(8, 0); mark(1'b1, 2'd0, 4'h5);
    rd(OFFSET_RESULT_UP, d); chk(d, exp_upper(2'd0, 4'h3, 2'd0, 4'h5, 20'h00008));
    rd(OFFSET_RESULT_LOW, d); chk(d, 16'h0008);
    tally_and_finish();
  end
endmodule : tb_latency_stopwatch
